//--- hw/cell_input_pkg.sv
package cell_input_pkg;

   // register byte offsets on the bus
   localparam logic [3:0]  OFF_CONTROL_HIGH = 4'h0;
   localparam logic [3:0]  OFF_SOURCE_SEL   = 4'h4;
   localparam logic [3:0]  OFF_GATE_EN_LOW  = 4'h8;

   // implemented bits of each register
   localparam logic [15:0] MASK_CONTROL_HIGH = 16'h000F;
   localparam logic [15:0] MASK_SOURCE_SEL   = 16'h7777;
   localparam logic [15:0] MASK_GATE_EN_LOW  = 16'hFFFF;

   // reset values
   localparam logic [15:0] RST_CONTROL_HIGH = 16'h0000;
   localparam logic [15:0] RST_SOURCE_SEL   = 16'h0000;
   localparam logic [15:0] RST_GATE_EN_LOW  = 16'h0000;

   // field layout
   localparam int          GATE_INVERT_LSB  = 0;
   localparam int          SEL_FIELD_STRIDE = 4;
   localparam int          SEL_CODE_W       = 3;
   localparam int          GATE_EN_W        = 8;
   localparam int          NUM_GATES        = 4;
   localparam int          NUM_SOURCES      = 8;

   // selector codes shared by all four selectors
   localparam logic [2:0]  CODE_PIN         = 3'h0;
   localparam logic [2:0]  CODE_CELL_OUT    = 3'h1;
   localparam logic [2:0]  CODE_COMPARATOR  = 3'h2;
   localparam logic [2:0]  CODE_SERIAL      = 3'h3;
   localparam logic [2:0]  CODE_EVENT       = 3'h4;
   localparam logic [2:0]  CODE_LOW         = 3'h5;
   localparam logic [2:0]  CODE_FLAG_A      = 3'h6;
   localparam logic [2:0]  CODE_FLAG_B      = 3'h7;

   // bus handshake states
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_e;

endpackage

//--- hw/source_selector.sv
`timescale 1ns/100ps
// one eight-way data source multiplexer
module source_selector
   import cell_input_pkg::*;
(
   input  wire logic [NUM_SOURCES-1:0] candidates,
   input  wire logic [SEL_CODE_W-1:0]  code,
   output logic                        data
);

   // the low code is forced here so no caller can wire it wrong
   always_comb begin
      if (code == CODE_LOW) begin
         data = 1'b0;
      end else begin
         data = candidates[code];
      end
   end

endmodule

//--- hw/logic_cell_input_select.sv
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
// input selection front end of one configurable logic cell
module logic_cell_input_select
   import cell_input_pkg::*;
#(
   parameter int CELL_INDEX = 1
)
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // register bus
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // candidate sources
   input  wire logic        input_pin_a,
   input  wire logic        input_pin_b,
   input  wire logic        instruction_cycle_clock,
   input  wire logic        secondary_osc_clock,
   input  wire logic        low_power_rc_clock,
   input  wire logic        fast_rc_clock,
   input  wire logic        capture_unit1_compare_flag,
   input  wire logic        capture_unit2_compare_flag,
   input  wire logic        capture_unit3_compare_flag,
   input  wire logic        capture_unit4_compare_flag,
   input  wire logic        capture_unit5_compare_flag,
   input  wire logic        comparator1_out,
   input  wire logic        comparator2_out,
   input  wire logic        comparator3_out,
   input  wire logic        serial_port1_tx,
   input  wire logic        serial_port2_tx,
   input  wire logic        serial_port1_rx,
   input  wire logic        serial_port2_rx,
   input  wire logic        serial_periph1_data_out,
   input  wire logic        serial_periph2_data_out,
   input  wire logic        serial_periph1_data_in,
   input  wire logic        serial_periph2_data_in,
   input  wire logic        converter_end_of_conversion,
   input  wire logic        charge_time_unit_trigger,
   input  wire logic        own_cell_out,
   input  wire logic        other_cell_out,
   // gate 3 and 4 enables come from the neighbouring register
   input  wire logic [15:0] gate_enable_high,
   // gate results after polarity, towards the logic function
   output logic [3:0]       gate_out
);

   // merge a 16-bit write under byte enables and implemented-bit mask
   function automatic logic [15:0] merge_write(input logic [15:0] old_value,
                                               input logic [15:0] wdata,
                                               input logic [1:0]  be,
                                               input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}};
      return ((old_value & ~lanes) | (wdata & lanes)) & mask;
   endfunction

   // OR of enabled true and negated selector outputs for one gate
   function automatic logic gate_or(input logic [7:0] en, input logic [3:0] d);
      logic acc;
      acc = 1'b0;
      for (int k = 0; k < 4; k++) begin
         acc = acc | (en[2*k+1] & d[k]) | (en[2*k] & ~d[k]);
      end
      return acc;
   endfunction

   logic [15:0]           control_high;
   logic [15:0]           input_source_select;
   logic [15:0]           gate_enable_low;
   bus_state_e            bus_state;
   bus_state_e            next_bus_state;
   logic                  request;
   logic                  commit;
   logic [31:0]           next_readdata;
   logic [NUM_SOURCES-1:0] candidates [NUM_GATES];
   logic [3:0]            sel_data;
   logic [3:0]            gate_raw;
   logic [7:0]            gate_en [NUM_GATES];
   logic [3:0]            gate_invert;
   logic                  serial_tx_src;
   logic                  serial_rx_src;
   logic                  periph_out_src;
   logic                  periph_in_src;

   assign request = read | write;
   // a write lands only at the edge where the master sees waitrequest low
   assign commit  = write & (bus_state == BUS_ANSWER);

   // bus handshake: one wait cycle, then answer for exactly one cycle
   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         BUS_IDLE: begin
            if (request) begin
               next_bus_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_state   <= BUS_IDLE;
         waitrequest <= 1'b1;
      end else begin
         bus_state   <= next_bus_state;
         waitrequest <= (next_bus_state != BUS_ANSWER);
      end
   end

   // read mux; unmapped addresses and unimplemented bits return zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (address)
         OFF_CONTROL_HIGH: next_readdata = {16'h0000, control_high & MASK_CONTROL_HIGH};
         OFF_SOURCE_SEL:   next_readdata = {16'h0000, input_source_select & MASK_SOURCE_SEL};
         OFF_GATE_EN_LOW:  next_readdata = {16'h0000, gate_enable_low};
         default:          next_readdata = 32'h0000_0000;
      endcase
   end

   // read data captured during the wait cycle so it stands at the answer edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         readdata <= 32'h0000_0000;
      end else if (read && bus_state == BUS_IDLE) begin
         readdata <= next_readdata;
      end
   end

   // register writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         control_high        <= RST_CONTROL_HIGH;
         input_source_select <= RST_SOURCE_SEL;
         gate_enable_low     <= RST_GATE_EN_LOW;
      end else if (commit) begin
         if (address == OFF_CONTROL_HIGH) begin
            control_high <= merge_write(control_high, writedata[15:0], byteenable[1:0], MASK_CONTROL_HIGH);
         end
         if (address == OFF_SOURCE_SEL) begin
            input_source_select <= merge_write(input_source_select, writedata[15:0], byteenable[1:0],
                                               MASK_SOURCE_SEL);
         end
         if (address == OFF_GATE_EN_LOW) begin
            gate_enable_low <= merge_write(gate_enable_low, writedata[15:0], byteenable[1:0],
                                           MASK_GATE_EN_LOW);
         end
      end
   end

   // peripheral instance follows the cell index; cell 1 uses instance 1
   assign serial_tx_src  = (CELL_INDEX == 1) ? serial_port1_tx         : serial_port2_tx;
   assign serial_rx_src  = (CELL_INDEX == 1) ? serial_port1_rx         : serial_port2_rx;
   assign periph_out_src = (CELL_INDEX == 1) ? serial_periph1_data_out : serial_periph2_data_out;
   assign periph_in_src  = (CELL_INDEX == 1) ? serial_periph1_data_in  : serial_periph2_data_in;

   // candidate lists, index equals selector code; index 5 is overridden low
   assign candidates[0] = {capture_unit5_compare_flag, capture_unit4_compare_flag, 1'b0, fast_rc_clock,
                           low_power_rc_clock, secondary_osc_clock, instruction_cycle_clock,
                           input_pin_a};
   assign candidates[1] = {capture_unit2_compare_flag, capture_unit1_compare_flag, 1'b0,
                           converter_end_of_conversion, serial_tx_src, comparator1_out, other_cell_out,
                           input_pin_b};
   assign candidates[2] = {capture_unit3_compare_flag, capture_unit2_compare_flag, 1'b0, serial_rx_src,
                           periph_out_src, comparator2_out, own_cell_out, input_pin_a};
   assign candidates[3] = {capture_unit3_compare_flag, capture_unit1_compare_flag, 1'b0,
                           charge_time_unit_trigger, periph_in_src, comparator3_out, other_cell_out,
                           input_pin_b};

   // gate enables: low register holds gates 1 and 2, bit 8 is gate 2 source 1 negated
   assign gate_en[0]  = gate_enable_low[7:0];
   assign gate_en[1]  = gate_enable_low[15:8];
   assign gate_en[2]  = gate_enable_high[7:0];
   assign gate_en[3]  = gate_enable_high[15:8];
   assign gate_invert = control_high[GATE_INVERT_LSB +: NUM_GATES];

   // four selectors and four gates
   for (genvar g = 0; g < NUM_GATES; g++) begin : gen_path
      source_selector u_sel (
         .candidates (candidates[g]),
         .code       (input_source_select[g*SEL_FIELD_STRIDE +: SEL_CODE_W]),
         .data       (sel_data[g])
      );
      assign gate_raw[g] = gate_or(gate_en[g], sel_data);
   end

   // registered gate outputs; clock-like sources therefore pass with one cycle of delay
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gate_out <= 4'h0;
      end else begin
         gate_out <= gate_raw ^ gate_invert;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_answer_bound: assert property (
      (request && waitrequest) |-> ##[1:2] !waitrequest)
      else $error("bus request not answered within two cycles");

   chk_high_zero: assert property (
      (read && !waitrequest && address == OFF_CONTROL_HIGH) |-> (readdata[31:4] == 28'h0000000))
      else $error("control high upper bits not zero");

   chk_sel_gaps: assert property (
      (read && !waitrequest && address == OFF_SOURCE_SEL) |->
      (readdata[3] == 1'b0 && readdata[7] == 1'b0 && readdata[11] == 1'b0 && readdata[15] == 1'b0))
      else $error("selector gap bits not zero");

   chk_sel_write: assert property (
      (commit && address == OFF_SOURCE_SEL && byteenable == 4'hF) |=>
      (input_source_select == ($past(writedata[15:0]) & MASK_SOURCE_SEL)))
      else $error("selector write not stored");

   chk_low_code: assert property (
      (input_source_select[14:12] == CODE_LOW) |-> !sel_data[3])
      else $error("low code did not give zero");

   chk_sel1_map: assert property (
      (input_source_select[2:0] == CODE_EVENT) |-> (sel_data[0] == fast_rc_clock))
      else $error("selector 1 event code wrong source");

   chk_sel2_map: assert property (
      (input_source_select[6:4] == CODE_CELL_OUT) |-> (sel_data[1] == other_cell_out))
      else $error("selector 2 cell code wrong source");

   chk_sel3_map: assert property (
      (input_source_select[10:8] == CODE_CELL_OUT) |-> (sel_data[2] == own_cell_out))
      else $error("selector 3 cell code wrong source");

   chk_sel4_map: assert property (
      (input_source_select[14:12] == CODE_SERIAL) |-> (sel_data[3] == periph_in_src))
      else $error("selector 4 serial code wrong source");

   chk_instance_pick: assert property (
      (input_source_select[6:4] == CODE_SERIAL) |->
      (sel_data[1] == ((CELL_INDEX == 1) ? serial_port1_tx : serial_port2_tx)))
      else $error("serial transmit from wrong instance");

   chk_gate_or: assert property (
      1'b1 |=> (gate_out[0] == ($past(gate_invert[0]) ^
                (|($past(gate_enable_low[7:0]) & {$past(sel_data[3]), ~$past(sel_data[3]),
                   $past(sel_data[2]), ~$past(sel_data[2]), $past(sel_data[1]), ~$past(sel_data[1]),
                   $past(sel_data[0]), ~$past(sel_data[0])})))))
      else $error("gate 1 result wrong");

   chk_true_only: assert property (
      (gate_enable_low[7:0] == 8'h02 && control_high[0] == 1'b0) |=> (gate_out[0] == $past(sel_data[0])))
      else $error("true enable did not pass source");

   chk_neg_bit8: assert property (
      (gate_enable_low[15:8] == 8'h01 && control_high[1] == 1'b1) |=> (gate_out[1] == $past(sel_data[0])))
      else $error("bit 8 not gate 2 source 1 negated");

   chk_invert: assert property (
      (gate_en[3] == 8'h00) |=> (gate_out[3] == $past(gate_invert[3])))
      else $error("gate 4 invert wrong");

   // gate 2 takes the high byte, whose lowest bit is source 1 negated
   chk_gate2_or: assert property (
      1'b1 |=> (gate_out[1] == ($past(gate_invert[1]) ^
                (|($past(gate_enable_low[15:8]) & {$past(sel_data[3]), ~$past(sel_data[3]),
                   $past(sel_data[2]), ~$past(sel_data[2]), $past(sel_data[1]), ~$past(sel_data[1]),
                   $past(sel_data[0]), ~$past(sel_data[0])})))))
      else $error("gate 2 result wrong");

   // a lone negated enable must give the inverse of the source
   chk_neg_only: assert property (
      (gate_enable_low[7:0] == 8'h01 && control_high[0] == 1'b0) |=> (gate_out[0] == !$past(sel_data[0])))
      else $error("negated enable did not invert source");

   // only the four invert bits may be kept
   chk_ctl_write: assert property (
      (commit && address == OFF_CONTROL_HIGH && byteenable[0]) |=>
      (control_high == ($past(writedata[15:0]) & MASK_CONTROL_HIGH)))
      else $error("gate invert write not stored");

   chk_first_low_code: assert property (
      (input_source_select[2:0] == CODE_LOW) |-> !sel_data[0])
      else $error("selector 1 low code did not give zero");

   chk_enable_readback: assert property (
      (read && !waitrequest && address == OFF_GATE_EN_LOW) |-> (readdata[15:0] == gate_enable_low))
      else $error("gate enable read back wrong");

   // an answer lasts one cycle, so a held request is taken again only after a new wait cycle
   chk_wait_pulse: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   cov_write_sel: cover property (commit && address == OFF_SOURCE_SEL);
   cov_read_high: cover property (read && !waitrequest && address == OFF_CONTROL_HIGH);
   cov_gate_rise: cover property (!gate_out[1] ##1 gate_out[1]);
   cov_low_code:  cover property (input_source_select[2:0] == CODE_LOW && gate_enable_low[0]);
   cov_bit8_neg:  cover property (gate_enable_low[8] && gate_out[1]);

endmodule

//--- testbench/source_pool_model.sv
`timescale 1ns/100ps
// pins and on-chip peripheral outputs that feed the cell's data selectors
module source_pool_model (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [25:0] pattern,
   output logic [25:0]      src
);
   // sources are synchronous to core_clk, so they only move just after an edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         src <= 26'h0000000;
      end else begin
         src <= pattern;
      end
   end
endmodule

//--- testbench/logic_cell_input_select_test.sv
`timescale 1ns/100ps
// both cells side by side: same bus, same sources, own serial instance each
module logic_cell_input_select_test import cell_input_pkg::*; ;
   logic        core_clk;
   logic        resetn;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [3:0]  byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata [2];
   logic [1:0]  waitrequest;
   logic [3:0]  gate_out [2];
   logic [25:0] pattern;
   logic [25:0] src;
   logic [15:0] gate_enable_high;
   logic [15:0] ctl, sel, gen;
   logic [31:0] rd [2];
   logic [31:0] exp_word;
   logic [31:0] got_word;
   int          n_fail;
   int          check_count;
   int          seed;
   // source index per selector and code, -1 is the constant low code
   int          src_map [4][8] = '{'{0, 2, 3, 4, 5, -1, 9, 10}, '{1, 25, 11, 14, 22, -1, 6, 7},
                                   '{0, 24, 12, 18, 16, -1, 7, 8}, '{1, 25, 13, 20, 23, -1, 6, 8}};

   for (genvar k = 0; k < 2; k++) begin : gen_cell
      logic_cell_input_select #(.CELL_INDEX(k + 1)) logic_cell_input_select_i (
         .core_clk(core_clk), .resetn(resetn), .address(address), .read(read), .write(write),
         .byteenable(byteenable), .writedata(writedata), .readdata(readdata[k]), .waitrequest(waitrequest[k]),
         .input_pin_a(src[0]), .input_pin_b(src[1]), .instruction_cycle_clock(src[2]), .secondary_osc_clock(src[3]),
         .low_power_rc_clock(src[4]), .fast_rc_clock(src[5]), .capture_unit1_compare_flag(src[6]),
         .capture_unit2_compare_flag(src[7]), .capture_unit3_compare_flag(src[8]),
         .capture_unit4_compare_flag(src[9]), .capture_unit5_compare_flag(src[10]), .comparator1_out(src[11]),
         .comparator2_out(src[12]), .comparator3_out(src[13]), .serial_port1_tx(src[14]), .serial_port2_tx(src[15]),
         .serial_port1_rx(src[16]), .serial_port2_rx(src[17]), .serial_periph1_data_out(src[18]),
         .serial_periph2_data_out(src[19]), .serial_periph1_data_in(src[20]), .serial_periph2_data_in(src[21]),
         .converter_end_of_conversion(src[22]), .charge_time_unit_trigger(src[23]), .own_cell_out(src[24]),
         .other_cell_out(src[25]), .gate_enable_high(gate_enable_high), .gate_out(gate_out[k]));
   end

   source_pool_model source_pool_model_i (.core_clk(core_clk), .resetn(resetn), .pattern(pattern), .src(src));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // gate result from the written settings; serial sources shift by one for cell 2
   function automatic logic [3:0] exp_gate(input int cell_no, input logic [15:0] c, s, gl, gh, input logic [25:0] v);
      logic [31:0] en;
      logic [3:0]  d;
      logic [3:0]  r;
      logic        acc;
      int          idx;
      en = {gh, gl};
      for (int j = 0; j < 4; j++) begin
         idx = src_map[j][s[4 * j +: 3]];
         if (idx inside {14, 16, 18, 20}) idx += cell_no - 1;
         d[j] = (idx < 0) ? 1'b0 : v[idx];
      end
      for (int g = 0; g < 4; g++) begin
         acc = 1'b0;
         for (int j = 0; j < 4; j++) acc |= (en[8 * g + 2 * j + 1] & d[j]) | (en[8 * g + 2 * j] & ~d[j]);
         r[g] = acc ^ c[g];
      end
      return r;
   endfunction

   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         check_count++;
         if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_fail++;
         end
      end
   endtask

   // one avalon transfer; request held until waitrequest is seen low at an edge
   task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [15:0] d);
      int n;
      begin
         n = 0;
         @(posedge core_clk);
         address <= a;
         write <= wr;
         read <= ~wr;
         byteenable <= be;
         writedata <= {16'h0000, d};
         do begin
            @(posedge core_clk);
            n++;
         end while (waitrequest[0] !== 1'b0 && n < 50);
         rd[0] = readdata[0];
         rd[1] = readdata[1];
         read <= 1'b0;
         write <= 1'b0;
         check("waitrequest cell 2", 32'h00000000, {31'h00000000, waitrequest[1]});
         if (n >= 50) begin
            $display("Error bus answer missing");
            n_fail++;
            give_verdict();
         end
      end
   endtask

   task chk_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
      begin
         bus_xfer(1'b0, a, 4'hF, 16'h0000);
         check(what, exp, rd[0]);
         check(what, exp, rd[1]);
      end
   endtask

   task reset_dut;
      begin
         @(posedge core_clk);
         resetn <= 1'b0;
         repeat (2) @(posedge core_clk);
         resetn <= 1'b1;
      end
   endtask

   initial begin
      #100000;
      $display("Error run did not finish in time");
      n_fail++;
      give_verdict();
   end

   initial begin
      seed = 32'hd624;
      n_fail = 0;
      check_count = 0;
      resetn = 1'b0;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = 32'h00000000;
      pattern = 26'h0000000;
      gate_enable_high = 16'h0000;
      reset_dut();
      // reset values, then all ones to see which bits are kept
      chk_reg("control high reset", OFF_CONTROL_HIGH, 32'h00000000);
      chk_reg("source select reset", OFF_SOURCE_SEL, 32'h00000000);
      chk_reg("gate enable reset", OFF_GATE_EN_LOW, 32'h00000000);
      bus_xfer(1'b1, OFF_CONTROL_HIGH, 4'hF, 16'hFFFF);
      bus_xfer(1'b1, OFF_SOURCE_SEL, 4'hF, 16'hFFFF);
      bus_xfer(1'b1, OFF_GATE_EN_LOW, 4'hF, 16'hFFFF);
      bus_xfer(1'b1, 4'hC, 4'hF, 16'hFFFF);
      chk_reg("control high ones", OFF_CONTROL_HIGH, 32'h0000000F);
      chk_reg("source select ones", OFF_SOURCE_SEL, 32'h00007777);
      chk_reg("gate enable ones", OFF_GATE_EN_LOW, 32'h0000FFFF);
      chk_reg("unmapped read", 4'hC, 32'h00000000);
      bus_xfer(1'b1, OFF_GATE_EN_LOW, 4'h2, 16'h1234);
      chk_reg("gate enable upper lane", OFF_GATE_EN_LOW, 32'h000012FF);
      $display("test registers done");
      // random settings and sources; the first eight set every code on all selectors
      for (int i = 0; i < 300; i++) begin
         ctl = 16'($random(seed));
         sel = 16'($random(seed));
         gen = 16'($random(seed));
         if (i < 8) sel = {4{1'b0, i[2:0]}};
         // hand corners: lone true enable with bit 8 alone and gate 2 inverted, then a lone negated enable
         if (i == 8) begin
            ctl = 16'h0002;
            gen = 16'h0102;
         end
         if (i == 9) begin
            ctl = 16'h0000;
            gen = 16'h0001;
         end
         bus_xfer(1'b1, OFF_CONTROL_HIGH, 4'hF, ctl);
         bus_xfer(1'b1, OFF_SOURCE_SEL, 4'hF, sel);
         bus_xfer(1'b1, OFF_GATE_EN_LOW, 4'hF, gen);
         pattern <= 26'($random(seed));
         gate_enable_high <= (i == 8) ? 16'h00A5 : 16'($random(seed)); // gate 4 fully off once
         repeat (3) @(posedge core_clk);
         for (int k = 0; k < 2; k++) begin
            exp_word = {28'h0000000, exp_gate(k + 1, ctl, sel, gen, gate_enable_high, src)};
            got_word = {28'h0000000, gate_out[k]};
            check("gate_out", exp_word, got_word);
         end
      end
      $display("test gate paths done");
      // reset in mid-run must clear control high and the gate enables
      reset_dut();
      chk_reg("control high after reset", OFF_CONTROL_HIGH, 32'h00000000);
      chk_reg("gate enable after reset", OFF_GATE_EN_LOW, 32'h00000000);
      exp_word = {28'h0000000, exp_gate(1, 16'h0000, 16'h0000, 16'h0000, gate_enable_high, src)};
      got_word = {28'h0000000, gate_out[0]};
      check("gate_out after reset", exp_word, got_word);
      $display("test second reset done");
      give_verdict();
   end
endmodule
